// ===== core/ext_pin_sync.sv
module ext_pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // only a level seen on two stages in a row is accepted
    if (s_q.s2 == s_q.s3) begin
      s_d.stable = s_q.s3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // pins idle high: no false active level while the stages fill
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.stable;
endmodule // ext_pin_sync

// ===== core/irq_pkg.sv
package irq_pkg;
  // byte addresses of the registers on the bus
  localparam logic [7:0] OFF_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] OFF_ENABLE_MASK = 8'hA8;
  localparam logic [7:0] OFF_PRIORITY = 8'hB8;
  localparam logic [7:0] OFF_PENDING = 8'hC0;
  localparam logic [7:0] OFF_STATUS = 8'hC4;
  localparam logic [7:0] OFF_EXT_PIN_CONFIG = 8'hE4;
  localparam logic [7:0] OFF_EXT_ENABLE = 8'hE8;
  localparam logic [7:0] OFF_EXT_PRIORITY = 8'hF8;

  // reset values
  localparam logic [7:0] RST_ENABLE_MASK = 8'h00;
  localparam logic [6:0] RST_PRIORITY = 7'h00;
  localparam logic [7:0] RST_EXT_ENABLE = 8'h00;
  localparam logic [7:0] RST_EXT_PRIORITY = 8'h00;
  localparam logic [7:0] RST_EXT_PIN_CONFIG = 8'h01;
  localparam logic [3:0] RST_TIMER_CTL = 4'h0;
  localparam logic [15:0] RST_VECTOR = 16'h0000;

  // enable register fields
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  // priority register bit 7 has no storage and reads one
  localparam int PRIORITY_UNUSED_BIT = 7;
  // extended registers: bits 1 and 6 are reserved, read zero
  localparam logic [7:0] EXT_WRITE_MASK = 8'hBD;

  // timer control register fields
  localparam int TC_EXT0_EDGE_SELECT = 0;
  localparam int TC_EXT0_PENDING = 1;
  localparam int TC_EXT1_EDGE_SELECT = 2;
  localparam int TC_EXT1_PENDING = 3;
  localparam int TC_TIMER0_RUN = 4;
  localparam int TC_TIMER0_OVERFLOW = 5;
  localparam int TC_TIMER1_RUN = 6;
  localparam int TC_TIMER1_OVERFLOW = 7;

  // pin config fields: pin select [2:0]/[6:4], polarity 3/7
  localparam int EXT0_POLARITY_BIT = 3;
  localparam int EXT1_POLARITY_BIT = 7;
  localparam int EXT0_SELECT_LSB = 0;
  localparam int EXT1_SELECT_LSB = 4;

  // fixed order numbers of the sources
  localparam int NUM_ORDERS = 15;
  localparam logic [3:0] ORD_EXT0 = 4'h0;
  localparam logic [3:0] ORD_TIMER0 = 4'h1;
  localparam logic [3:0] ORD_EXT1 = 4'h2;
  localparam logic [3:0] ORD_TIMER1 = 4'h3;
  localparam int FIRST_PERIPH_ORDER = 4;
  // orders 8 and 13 are reserved: 13 live sources
  localparam logic [14:0] VALID_ORDERS = 15'h5EFF;

  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam int CALL_CYCLES = 4;
endpackage : irq_pkg

// ===== core/two_level_vectored_interrupt_unit.sv
// What this block does
// R1: thirteen sources, each pending, enable, priority
// R2: software-set pending flag acts like hardware; here not for externals in level mode
// R3: edge/level select and polarity per input
// R4: external inputs watch selected pin, never drive
// R5: external pending flags at timer control 1,3
// R6: edge-mode external flag cleared on vectoring
// R7: level-mode external flag follows active input
// R8: level source holds request until recognised
// R9: level source drops request before routine ends
// R10: high priority preempts running low routine
// R11: running high routine is never preempted
// R12: all priorities reset to low
// R13: high level first, then lowest order
// R14: decode each clock, detect plus four-cycle call
// R15: one instruction completes after return first
// R16: worst case eighteen cycles without nesting
// R17: equal or lower waits for return plus one
// R18: vector three plus eight per order, reset zero
// R19: externals and basic timers cleared on vectoring; here externals only in edge mode
// R20: global enable bit seven gates all sources
// R21: enable register layout at A8, resets zero
// R22: enabled set flag requests call after instruction
// R23: flag left set after return re-requests
// R24: track level in service, release on return
//
// Our own choice: the Wishbone register port.
module two_level_vectored_interrupt_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] port_pins_i,
  input wire logic timer0_ovf_i,
  input wire logic timer1_ovf_i,
  input wire logic [14:4] periph_evt_i,
  input wire logic instr_done_i,
  input wire logic return_from_irq_done_i,
  output logic irq_req_o,
  output logic vector_call_o,
  output logic [15:0] vector_o
);
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CALL
  } call_state_t;

  typedef struct packed {
    call_state_t state;
    logic [1:0] call_cnt;
    logic [7:0] enable_mask;
    logic [6:0] priority_bits;
    logic [7:0] ext_enable;
    logic [7:0] ext_priority;
    logic [7:0] pin_config;
    logic [3:0] timer_ctl;
    logic [14:0] pending;
    logic [1:0] ext_prev_active;
    logic req;
    logic req_high;
    logic [3:0] req_order;
    logic in_service_low;
    logic in_service_high;
    logic [15:0] vector;
    logic call;
    logic ack;
    logic [31:0] rdata;
  } unit_state_t;

  localparam logic [1:0] CALL_LAST = 2'(irq_pkg::CALL_CYCLES - 1);

  unit_state_t s_q;
  unit_state_t s_d;
  logic [1:0] ext_level;
  logic [2:0] ext0_sel;
  logic [2:0] ext1_sel;

  assign ext0_sel = s_q.pin_config[irq_pkg::EXT0_SELECT_LSB +: 3];
  assign ext1_sel = s_q.pin_config[irq_pkg::EXT1_SELECT_LSB +: 3];

  // R4 observe only pins
  ext_pin_sync ext0_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port_pins_i[ext0_sel]),
    .level_o(ext_level[0])
  );

  ext_pin_sync ext1_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port_pins_i[ext1_sel]),
    .level_o(ext_level[1])
  );

  function automatic logic [3:0] lowest_set(input logic [14:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = irq_pkg::NUM_ORDERS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  logic [14:0] enable_all;
  logic [14:0] priority_all;
  logic [14:0] eligible;
  logic [14:0] cand_high;
  logic [14:0] cand_low;
  logic [1:0] ext_active;
  logic [1:0] ext_edge_mode;
  logic [1:0] ext_polarity;
  logic bus_access;
  logic [7:0] word_addr;
  logic [7:0] timer_ctl_view;

  always_comb begin
    enable_all = {s_q.ext_enable, s_q.enable_mask[6:0]};
    priority_all = {s_q.ext_priority, s_q.priority_bits};
    // R20 global gate
    eligible = s_q.pending & enable_all & irq_pkg::VALID_ORDERS
      & {irq_pkg::NUM_ORDERS{s_q.enable_mask[irq_pkg::GLOBAL_IRQ_ENABLE_BIT]}};
    cand_high = eligible & priority_all;
    cand_low = eligible & ~priority_all;
    ext_polarity = {s_q.pin_config[irq_pkg::EXT1_POLARITY_BIT],
                    s_q.pin_config[irq_pkg::EXT0_POLARITY_BIT]};
    ext_edge_mode = {s_q.timer_ctl[1], s_q.timer_ctl[0]};
    // R3 polarity one means active high
    ext_active = ~(ext_level ^ ext_polarity);
    // R5 pending bits at 1 and 3
    timer_ctl_view = {s_q.pending[irq_pkg::ORD_TIMER1], s_q.timer_ctl[3],
                      s_q.pending[irq_pkg::ORD_TIMER0], s_q.timer_ctl[2],
                      s_q.pending[irq_pkg::ORD_EXT1], s_q.timer_ctl[1],
                      s_q.pending[irq_pkg::ORD_EXT0], s_q.timer_ctl[0]};
    bus_access = wb_cyc_i & wb_stb_i & ~s_q.ack;
    word_addr = {wb_adr_i[7:2], 2'b00};
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.ext_prev_active = ext_active;

    if (bus_access) begin
      s_d.ack = 1'b1;
      s_d.rdata = 32'h0000_0000;
      unique case (word_addr)
        irq_pkg::OFF_TIMER_CONTROL: s_d.rdata[7:0] = timer_ctl_view;
        irq_pkg::OFF_ENABLE_MASK: s_d.rdata[7:0] = s_q.enable_mask;
        irq_pkg::OFF_PRIORITY: begin
          s_d.rdata[7:0] = {1'b1, s_q.priority_bits};
        end
        irq_pkg::OFF_PENDING: s_d.rdata[14:0] = s_q.pending;
        irq_pkg::OFF_STATUS: begin
          s_d.rdata[0] = s_q.in_service_low;
          s_d.rdata[1] = s_q.in_service_high;
          s_d.rdata[2] = s_q.req;
          s_d.rdata[3] = s_q.req_high;
          s_d.rdata[7:4] = s_q.req_order;
        end
        irq_pkg::OFF_EXT_PIN_CONFIG: s_d.rdata[7:0] = s_q.pin_config;
        irq_pkg::OFF_EXT_ENABLE: s_d.rdata[7:0] = s_q.ext_enable;
        irq_pkg::OFF_EXT_PRIORITY: s_d.rdata[7:0] = s_q.ext_priority;
        default: s_d.rdata = 32'h0000_0000;
      endcase

      if (wb_we_i && wb_sel_i[0]) begin
        unique case (word_addr)
          irq_pkg::OFF_TIMER_CONTROL: begin
            s_d.timer_ctl = {wb_dat_i[irq_pkg::TC_TIMER1_RUN],
                             wb_dat_i[irq_pkg::TC_TIMER0_RUN],
                             wb_dat_i[irq_pkg::TC_EXT1_EDGE_SELECT],
                             wb_dat_i[irq_pkg::TC_EXT0_EDGE_SELECT]};
            // R2 software may raise any of these flags, except an external one in level mode
            s_d.pending[irq_pkg::ORD_EXT0] = wb_dat_i[irq_pkg::TC_EXT0_PENDING];
            s_d.pending[irq_pkg::ORD_TIMER0] = wb_dat_i[irq_pkg::TC_TIMER0_OVERFLOW];
            s_d.pending[irq_pkg::ORD_EXT1] = wb_dat_i[irq_pkg::TC_EXT1_PENDING];
            s_d.pending[irq_pkg::ORD_TIMER1] = wb_dat_i[irq_pkg::TC_TIMER1_OVERFLOW];
          end
          // R21 enable mask storage
          irq_pkg::OFF_ENABLE_MASK: s_d.enable_mask = wb_dat_i[7:0];
          irq_pkg::OFF_PRIORITY: s_d.priority_bits = wb_dat_i[6:0];
          irq_pkg::OFF_PENDING: begin
            s_d.pending[7:0] = wb_dat_i[7:0];
          end
          irq_pkg::OFF_EXT_PIN_CONFIG: s_d.pin_config = wb_dat_i[7:0];
          irq_pkg::OFF_EXT_ENABLE: begin
            s_d.ext_enable = wb_dat_i[7:0] & irq_pkg::EXT_WRITE_MASK;
          end
          irq_pkg::OFF_EXT_PRIORITY: begin
            s_d.ext_priority = wb_dat_i[7:0] & irq_pkg::EXT_WRITE_MASK;
          end
          default: s_d.rdata = s_d.rdata;
        endcase
      end
      if (wb_we_i && wb_sel_i[1] && word_addr == irq_pkg::OFF_PENDING) begin
        s_d.pending[14:8] = wb_dat_i[14:8] & irq_pkg::VALID_ORDERS[14:8];
      end
      // reserved orders never hold a flag
      s_d.pending[7:0] = s_d.pending[7:0] & irq_pkg::VALID_ORDERS[7:0];
    end

    unique case (s_q.state)
      ST_IDLE: begin
        // R22 call only at an instruction boundary
        // R15 return completion is not a boundary for calls
        if (instr_done_i && s_q.req) begin
          s_d.state = ST_CALL;
          s_d.call_cnt = 2'b00;
          s_d.call = 1'b1;
          // R18 vector from order
          s_d.vector = irq_pkg::VECTOR_BASE + {9'h000, s_q.req_order, 3'b000};
          // R24 record level in service
          if (s_q.req_high) begin
            s_d.in_service_high = 1'b1;
          end else begin
            s_d.in_service_low = 1'b1;
          end
          // R19 hardware clear of the two timer flags; externals below in edge mode only
          if (s_q.req_order == irq_pkg::ORD_TIMER0 ||
              s_q.req_order == irq_pkg::ORD_TIMER1) begin
            s_d.pending[s_q.req_order] = 1'b0;
          end
          // R6 edge-mode clear on vectoring
          if (s_q.req_order == irq_pkg::ORD_EXT0 && ext_edge_mode[0]) begin
            s_d.pending[irq_pkg::ORD_EXT0] = 1'b0;
          end
          if (s_q.req_order == irq_pkg::ORD_EXT1 && ext_edge_mode[1]) begin
            s_d.pending[irq_pkg::ORD_EXT1] = 1'b0;
          end
        end
      end
      ST_CALL: begin
        // R14 four-cycle call
        if (s_q.call_cnt == CALL_LAST) begin
          s_d.state = ST_IDLE;
          s_d.call = 1'b0;
        end else begin
          s_d.call_cnt = s_q.call_cnt + 2'b01;
        end
      end
    endcase

    // R24 return releases the innermost level
    if (return_from_irq_done_i) begin
      if (s_q.in_service_high) begin
        s_d.in_service_high = 1'b0;
      end else begin
        s_d.in_service_low = 1'b0;
      end
    end

    // events applied last so a set beats a same-cycle clear
    if (timer0_ovf_i) begin
      s_d.pending[irq_pkg::ORD_TIMER0] = 1'b1;
    end
    if (timer1_ovf_i) begin
      s_d.pending[irq_pkg::ORD_TIMER1] = 1'b1;
    end
    // R1 peripheral sources stay set until software clears
    s_d.pending[14:4] = s_d.pending[14:4] | (periph_evt_i & irq_pkg::VALID_ORDERS[14:4]);

    for (int e = 0; e < 2; e++) begin
      if (ext_edge_mode[e]) begin
        // R3 edge mode catches inactive-to-active change
        if (ext_active[e] && !s_q.ext_prev_active[e]) begin
          s_d.pending[2 * e] = 1'b1;
        end
      end else begin
        // R7 level mode mirrors the input
        // R8 a pulse shorter than two clock cycles is lost
        s_d.pending[2 * e] = ext_active[e];
      end
    end

    // R13 high level first, lowest order within a level
    // R10 high may interrupt a low routine
    // R11 nothing enters while high runs
    // R17 equal or lower level waits for the return
    // R23 a flag left set requests again after return
    // decode against the level after this edge's return or call,
    // so only one instruction slips in between return and next call
    if (|cand_high && !s_d.in_service_high) begin
      s_d.req = 1'b1;
      s_d.req_high = 1'b1;
      s_d.req_order = lowest_set(cand_high);
    end else if (|cand_low && !s_d.in_service_high && !s_d.in_service_low) begin
      s_d.req = 1'b1;
      s_d.req_high = 1'b0;
      s_d.req_order = lowest_set(cand_low);
    end else begin
      s_d.req = 1'b0;
      s_d.req_high = 1'b0;
      s_d.req_order = 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.state <= ST_IDLE;
      s_q.call_cnt <= 2'b00;
      // R21 enable resets zero
      s_q.enable_mask <= irq_pkg::RST_ENABLE_MASK;
      // R12 low priority after reset
      s_q.priority_bits <= irq_pkg::RST_PRIORITY;
      s_q.ext_enable <= irq_pkg::RST_EXT_ENABLE;
      s_q.ext_priority <= irq_pkg::RST_EXT_PRIORITY;
      s_q.pin_config <= irq_pkg::RST_EXT_PIN_CONFIG;
      s_q.timer_ctl <= irq_pkg::RST_TIMER_CTL;
      s_q.pending <= '0;
      s_q.ext_prev_active <= 2'b00;
      s_q.req <= 1'b0;
      s_q.req_high <= 1'b0;
      s_q.req_order <= 4'h0;
      s_q.in_service_low <= 1'b0;
      s_q.in_service_high <= 1'b0;
      // R18 reset vector
      s_q.vector <= irq_pkg::RST_VECTOR;
      s_q.call <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // R9 a level still active after return re-requests
  assign irq_req_o = s_q.req;
  assign vector_call_o = s_q.call;
  assign vector_o = s_q.vector;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  // R16 worst case follows from decode plus cpu timing
endmodule // two_level_vectored_interrupt_unit

// ===== verif/cpu_model.sv
module cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic ret_req_i,
  input wire logic call_i,
  output logic instr_done_o,
  output logic ret_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  always_ff @(posedge clk_i) begin
    instr_done_o <= 1'b0;
    ret_done_o <= 1'b0;
    if (rst_i || call_i) begin
      wait_q <= 2'h0;
    end else if (slow_i && wait_q != 2'h2) begin
      wait_q <= wait_q + 2'h1;
    end else begin
      wait_q <= 2'h0;
      if (ret_req_i && !ret_done_o) begin
        ret_done_o <= 1'b1;
      end else begin
        instr_done_o <= 1'b1;
      end
    end
  end
endmodule // cpu_model

// ===== verif/irq_properties.sv
module irq_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic instr_done_i,
  input wire logic return_from_irq_done_i,
  input wire logic irq_req_o,
  input wire logic vector_call_o,
  input wire logic [15:0] vector_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  ack_answer_a: assert property (take |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  unmapped_zero_a: assert property (take && !wb_we_i && wb_adr_i == 8'h00 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  call_length_a: assert property ($rose(vector_call_o) |-> vector_call_o[*4] ##1 !vector_call_o)
    else $error("call not four cycles");
  call_cause_a: assert property ($rose(vector_call_o) |-> $past(instr_done_i) && $past(irq_req_o))
    else $error("call without request at boundary");
  vector_form_a: assert property ($rose(vector_call_o) |-> vector_o[2:0] == 3'h3 &&
    vector_o[15:7] == 9'h000 && vector_o[6:3] != 4'h8 && vector_o[6:3] != 4'hD)
    else $error("bad vector address");
  vector_hold_a: assert property (!$rose(vector_call_o) |-> $stable(vector_o))
    else $error("vector moved outside call");
  return_no_call_a: assert property (return_from_irq_done_i && !instr_done_i && !vector_call_o
    |=> !$rose(vector_call_o))
    else $error("call right after return");
  cover property ($rose(vector_call_o));
  cover property (return_from_irq_done_i ##[1:20] $rose(vector_call_o));
  cover property (take && wb_we_i);
endmodule // irq_properties

// ===== verif/two_level_vectored_interrupt_unit_tb.sv
module two_level_vectored_interrupt_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, t0 = 1'b0, t1 = 1'b0, slow = 1'b0, ret_req = 1'b0;
  logic ack, req, call, idone, rdone;
  logic [7:0] adr = 8'h00, pins = 8'hFF, q;
  logic [31:0] wdat = 32'h0, rdat;
  logic [14:4] evt = 11'h000;
  logic [3:0] sel = 4'h1;
  logic [15:0] vec;
  int num_errors = 0;
  int comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  two_level_vectored_interrupt_unit uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .port_pins_i(pins), .timer0_ovf_i(t0),
    .timer1_ovf_i(t1), .periph_evt_i(evt), .instr_done_i(idone), .return_from_irq_done_i(rdone),
    .irq_req_o(req), .vector_call_o(call), .vector_o(vec));
  cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .ret_req_i(ret_req),
    .call_i(call), .instr_done_o(idone), .ret_done_o(rdone));
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    num_errors++;
    $display("Error at %0t: timeout", $time);
    results();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) hang();
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({8'h00, q & m}, {8'h00, e});
  endtask
  task automatic wait_call(input logic [15:0] e);
    int n;
    n = 0;
    while (call !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) hang();
    chk(vec, e);
    repeat (5) @(posedge clk_i);
  endtask
  task automatic no_call(input int c);
    int n;
    n = 0;
    repeat (c) begin
      @(posedge clk_i);
      if (call !== 1'b0) n++;
    end
    chk(16'(n), 16'h0000);
  endtask
  task automatic ret_irq();
    int n;
    n = 0;
    ret_req <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rdone !== 1'b1 && n < 50);
    ret_req <= 1'b0;
    if (n >= 50) hang();
    // let the request rest one edge before another return
    @(posedge clk_i);
  endtask
  task automatic pin(input logic [7:0] v);
    pins <= v;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic s_reset();
    chk(vec, 16'h0000);
    chk({15'h0, req}, 16'h0000);
    rd(irq_pkg::OFF_ENABLE_MASK, 8'hFF, 8'h00);
    rd(irq_pkg::OFF_PRIORITY, 8'hFF, 8'h80);
    rd(8'h00, 8'hFF, 8'h00);
    $display("test reset done");
  endtask
  task automatic s_soft();
    wr(irq_pkg::OFF_PENDING, 8'h10);
    wr(irq_pkg::OFF_ENABLE_MASK, 8'h10);
    no_call(12);
    chk({15'h0, req}, 16'h0000);
    wr(irq_pkg::OFF_ENABLE_MASK, 8'h90);
    wait_call(16'h0023);
    rd(irq_pkg::OFF_STATUS, 8'h03, 8'h01);
    rd(irq_pkg::OFF_PENDING, 8'hFF, 8'h10);
    rd(irq_pkg::OFF_ENABLE_MASK, 8'hFF, 8'h90);
    wr(irq_pkg::OFF_PENDING, 8'h00);
    ret_irq();
    $display("test soft done");
  endtask
  task automatic s_prio();
    slow <= 1'b1;
    wr(irq_pkg::OFF_PRIORITY, 8'h28);
    wr(irq_pkg::OFF_ENABLE_MASK, 8'hAA);
    t0 <= 1'b1;
    t1 <= 1'b1;
    @(posedge clk_i);
    t0 <= 1'b0;
    t1 <= 1'b0;
    wait_call(16'h001B);
    no_call(30);
    rd(irq_pkg::OFF_STATUS, 8'h03, 8'h02);
    rd(irq_pkg::OFF_TIMER_CONTROL, 8'hA0, 8'h20);
    ret_irq();
    wait_call(16'h000B);
    evt[5] <= 1'b1;
    @(posedge clk_i);
    evt[5] <= 1'b0;
    wait_call(16'h002B);
    ret_irq();
    // sticky flag still set, so the routine is entered again
    wait_call(16'h002B);
    wr(irq_pkg::OFF_PENDING, 8'h00);
    ret_irq();
    ret_irq();
    slow <= 1'b0;
    $display("test priority done");
  endtask
  task automatic s_upper();
    wr(irq_pkg::OFF_ENABLE_MASK, 8'h80);
    wr(irq_pkg::OFF_EXT_ENABLE, 8'hFF);
    rd(irq_pkg::OFF_EXT_ENABLE, 8'hFF, 8'hBD);
    wr(irq_pkg::OFF_EXT_PRIORITY, 8'h80);
    // reserved orders 8 and 13 fire too and must never vector
    evt <= 11'h618;
    @(posedge clk_i);
    evt <= 11'h000;
    wait_call(16'h0073);
    sel <= 4'h3;
    wr(irq_pkg::OFF_PENDING, 8'h80);
    rd(irq_pkg::OFF_PENDING, 8'hFF, 8'h80);
    ret_irq();
    wait_call(16'h003B);
    wr(irq_pkg::OFF_PENDING, 8'h00);
    ret_irq();
    no_call(20);
    sel <= 4'h2;
    wr(irq_pkg::OFF_ENABLE_MASK, 8'h00);
    rd(irq_pkg::OFF_ENABLE_MASK, 8'hFF, 8'h80);
    sel <= 4'h1;
    $display("test upper sources done");
  endtask
  task automatic s_ext();
    pin(8'hFD);
    rd(irq_pkg::OFF_TIMER_CONTROL, 8'h02, 8'h02);
    pin(8'hFF);
    rd(irq_pkg::OFF_TIMER_CONTROL, 8'h02, 8'h00);
    wr(irq_pkg::OFF_EXT_PIN_CONFIG, 8'h09);
    pin(8'hFD);
    rd(irq_pkg::OFF_TIMER_CONTROL, 8'h02, 8'h00);
    wr(irq_pkg::OFF_TIMER_CONTROL, 8'h01);
    pin(8'hFF);
    rd(irq_pkg::OFF_TIMER_CONTROL, 8'h02, 8'h02);
    wr(irq_pkg::OFF_ENABLE_MASK, 8'h81);
    wait_call(16'h0003);
    rd(irq_pkg::OFF_TIMER_CONTROL, 8'h02, 8'h00);
    ret_irq();
    wr(irq_pkg::OFF_ENABLE_MASK, 8'h84);
    // level source held active until the call
    pins <= 8'hFE;
    wait_call(16'h0013);
    rd(irq_pkg::OFF_TIMER_CONTROL, 8'h08, 8'h08);
    pin(8'hFF);
    ret_irq();
    no_call(20);
    $display("test external done");
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset();
    s_soft();
    s_prio();
    s_upper();
    s_ext();
    results();
  end
endmodule // two_level_vectored_interrupt_unit_tb
bind two_level_vectored_interrupt_unit irq_properties props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_done_i(instr_done_i),
  .return_from_irq_done_i(return_from_irq_done_i), .irq_req_o(irq_req_o), .vector_call_o(vector_call_o),
  .vector_o(vector_o));
